// ===== mmad_pkg.sv
package mmad_pkg;

   // ----------------------------------------------------------------
   // Address map
   // ----------------------------------------------------------------
   localparam logic [19:0] PROG_TOP  = 20'h0FFFF;  // Last program byte
   localparam logic [15:0] ROM_LO    = 16'h0000;   // Internal ROM base
   localparam logic [15:0] ROM_HI    = 16'h1FFF;   // Internal ROM top
   localparam logic [15:0] BOOT_ADDR = 16'h0000;   // First fetch after reset
   localparam logic [15:0] VEC_LO    = 16'h0010;   // Interrupt entry base
   localparam logic [15:0] VEC_HI    = 16'h007F;   // Interrupt entry top
   localparam logic [15:0] RAM_LO    = 16'hFEC0;   // Internal RAM base
   localparam logic [15:0] RAM_HI    = 16'hFFBF;   // Internal RAM top
   localparam logic [7:0]  DIR_PAGE  = 8'hFF;      // Implied upper byte
   localparam logic [7:0]  DIR_LAST  = 8'hEF;      // Last direct byte served inside
   localparam logic [15:0] DMA_LO    = 16'hFF10;   // Micro DMA parameter base
   localparam logic [15:0] DMA_HI    = 16'hFF7F;   // Micro DMA parameter top
   localparam logic [15:0] IO_LO     = 16'hFFC0;   // Internal I/O base
   localparam logic [15:0] IO_HI     = 16'hFFEF;   // Internal I/O top
   localparam logic [15:0] XBANK_REG = 16'hFFEC;   // X bank register
   localparam logic [15:0] YBANK_REG = 16'hFFED;   // Y bank register

   // ----------------------------------------------------------------
   // Reset values and counts
   // ----------------------------------------------------------------
   localparam logic [3:0]  BANK_RST   = 4'h0;      // Bank bits after reset
   localparam logic [3:0]  BANK_FILL  = 4'hF;      // Unused bank bits read
   localparam logic [3:0]  BANK0      = 4'h0;      // Bank of internal resources
   localparam logic [1:0]  STROBE_MIN = 2'h3;      // Count that ends the four-cycle least strobe
   localparam logic [2:0]  SYNC_RST   = 3'h7;      // Synchroniser reset level

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {BANK_NONE, BANK_X, BANK_Y} mmad_bank_t;
   typedef enum logic [1:0] {RGN_ROM, RGN_RAM, RGN_IO, RGN_EXT} mmad_rgn_t;

   // CPU access request
   typedef struct packed {
      logic [19:0] addr;       // Full or 16-bit address
      logic [7:0]  direct_op;  // Short-form operand
      logic        direct;     // Use short-form operand
      logic        fetch;      // Program fetch
      logic        write;      // Write access
      logic [7:0]  wdata;      // Write data
      mmad_bank_t  bank;       // Bank register to apply
   } mmad_req_t;

   // Internal memory port
   typedef struct packed {
      logic [15:0] addr;       // Local address
      logic        rom_sel;    // ROM selected
      logic        ram_sel;    // RAM selected
      logic        io_sel;     // I/O area selected
      logic        we;         // Write enable
      logic [7:0]  wdata;      // Write data
   } mmad_int_t;

endpackage

// ===== mmad_decoder.sv
`timescale 1ns/100ps
module mmad_decoder (
   // Clock and reset
   input  wire logic                clk_in,
   input  wire logic                rst_in,
   // CPU request and answer
   input  wire logic                req_valid_in,
   input  wire mmad_pkg::mmad_req_t req_in,
   output logic                     req_ready_out,
   output logic                     done_out,
   output logic [7:0]               rdata_out,
   output logic [15:0]              boot_addr_out,
   // Internal memories
   output mmad_pkg::mmad_int_t      int_out,
   input  wire logic [7:0]          rom_rdata_in,
   input  wire logic [7:0]          ram_rdata_in,
   input  wire logic [7:0]          io_rdata_in,
   output logic                     vec_area_out,
   output logic                     dma_param_out,
   input  wire logic                micro_dma_en_in,
   // Straps and control
   input  wire logic                internal_rom_select_in,
   input  wire logic                wait_n_in,
   // Port 4 control
   input  wire logic [3:0]          p4_addr_sel_in,
   input  wire logic [3:0]          p4_port_in,
   // External bus pins
   input  wire logic [7:0]          p0_in,
   output logic [7:0]               p0_out,
   output logic                     p0_oe_out,
   output logic [7:0]               p1_out,
   output logic [7:0]               p2_out,
   output logic [3:0]               p4_out,
   output logic                     rd_n_out,
   output logic                     wr_n_out,
   output logic                     clk_out
);

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   logic [2:0] rom_sync_q;   // Strap sampling chain
   logic [2:0] rom_sync_d;   // Next strap chain
   logic [2:0] wait_sync_q;  // Wait sampling chain
   logic [2:0] wait_sync_d;  // Next wait chain
   logic       rom_sel_q;    // Accepted strap level
   logic       rom_sel_d;    // Next strap level
   logic       wait_n_q;     // Accepted wait level
   logic       wait_n_d;     // Next wait level
   // Shift pins in; a level counts once stages two and three agree
   always_comb begin
      rom_sync_d  = {rom_sync_q[1:0], internal_rom_select_in};
      wait_sync_d = {wait_sync_q[1:0], wait_n_in};
      rom_sel_d   = (rom_sync_q[2] == rom_sync_q[1]) ? rom_sync_q[2] : rom_sel_q;
      wait_n_d    = (wait_sync_q[2] == wait_sync_q[1]) ? wait_sync_q[2] : wait_n_q;
   end
   // Register synchroniser state
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         rom_sync_q  <= mmad_pkg::SYNC_RST;
         wait_sync_q <= mmad_pkg::SYNC_RST;
         rom_sel_q   <= 1'b1;
         wait_n_q    <= 1'b1;
      end else begin
         rom_sync_q  <= rom_sync_d;
         wait_sync_q <= wait_sync_d;
         rom_sel_q   <= rom_sel_d;
         wait_n_q    <= wait_n_d;
      end
   end

   // ----------------------------------------------------------------
   // Clock output divider
   // ----------------------------------------------------------------
   logic clk_div_q;  // Half-period phase
   logic clk_div_d;
   logic clk_q;      // Clock pin level
   logic clk_d;
   // Toggle every second cycle, quarter of the input rate
   always_comb begin
      clk_div_d = ~clk_div_q;
      clk_d     = clk_div_q ? ~clk_q : clk_q;
   end
   // Held high throughout reset
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         clk_div_q <= 1'b0;
         clk_q     <= 1'b1;
      end else begin
         clk_div_q <= clk_div_d;
         clk_q     <= clk_d;
      end
   end

   assign clk_out = clk_q;

   // ----------------------------------------------------------------
   // Address resolution
   // ----------------------------------------------------------------
   logic [19:0]         eff_addr;  // Resolved 20-bit address
   logic [15:0]         low_addr;  // Lower 16 bits
   mmad_pkg::mmad_rgn_t eff_rgn;   // Target region
   logic [3:0]          index_x_bank_q;  // X bank register
   logic [3:0]          index_y_bank_q;  // Y bank register
   // Form the address and pick the region that serves it
   always_comb begin
      // Short-form operand wins over any bank register
      eff_addr = req_in.addr;
      if (req_in.bank == mmad_pkg::BANK_X) eff_addr = {index_x_bank_q, req_in.addr[15:0]};
      if (req_in.bank == mmad_pkg::BANK_Y) eff_addr = {index_y_bank_q, req_in.addr[15:0]};
      if (req_in.direct) begin
         eff_addr = {mmad_pkg::BANK0, mmad_pkg::DIR_PAGE, req_in.direct_op};
      end
      // Fetches never leave the 64K program space
      eff_addr = req_in.fetch ? (eff_addr & mmad_pkg::PROG_TOP) : eff_addr;
      low_addr = eff_addr[15:0];
      eff_rgn  = mmad_pkg::RGN_EXT;
      if (eff_addr[19:16] == mmad_pkg::BANK0) begin
         if (rom_sel_q && low_addr <= mmad_pkg::ROM_HI) begin
            eff_rgn = mmad_pkg::RGN_ROM;
         end else if (low_addr >= mmad_pkg::RAM_LO && low_addr <= mmad_pkg::RAM_HI) begin
            eff_rgn = mmad_pkg::RGN_RAM;
         end else if (low_addr >= mmad_pkg::IO_LO && low_addr <= mmad_pkg::IO_HI) begin
            eff_rgn = mmad_pkg::RGN_IO;
         end
      end
   end

   // ----------------------------------------------------------------
   // Access sequencer
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {ST_IDLE, ST_INT, ST_SETUP, ST_STROBE, ST_DONE} mmad_state_t;
   mmad_state_t         state_q;   // Sequencer state
   mmad_state_t         state_d;
   logic [19:0]         addr_q;    // Latched address
   logic [19:0]         addr_d;
   mmad_pkg::mmad_rgn_t rgn_q;     // Latched region
   mmad_pkg::mmad_rgn_t rgn_d;
   logic                write_q;   // Latched direction
   logic                write_d;
   logic [7:0]          wdata_q;   // Latched write data
   logic [7:0]          wdata_d;
   logic [7:0]          rdata_q;   // Answer data
   logic [7:0]          rdata_d;
   logic [1:0]          cnt_q;     // Strobe length count
   logic [1:0]          cnt_d;
   logic [3:0]          index_x_bank_d;
   logic [3:0]          index_y_bank_d;
   logic [7:0]          io_rd;     // I/O read with bank registers merged

   // Bank registers read with unused bits as ones
   always_comb begin
      case (addr_q[15:0])
         mmad_pkg::XBANK_REG: io_rd = {mmad_pkg::BANK_FILL, index_x_bank_q};
         mmad_pkg::YBANK_REG: io_rd = {mmad_pkg::BANK_FILL, index_y_bank_q};
         default:             io_rd = io_rdata_in;
      endcase
   end

   // Next-state logic for every access
   always_comb begin
      state_d = state_q;
      addr_d  = addr_q;
      rgn_d   = rgn_q;
      write_d = write_q;
      wdata_d = wdata_q;
      rdata_d = rdata_q;
      cnt_d   = cnt_q;
      index_x_bank_d = index_x_bank_q;
      index_y_bank_d = index_y_bank_q;
      case (state_q)
         // Take one request at a time
         ST_IDLE: begin
            if (req_valid_in) begin
               addr_d  = eff_addr;
               rgn_d   = eff_rgn;
               write_d = req_in.write;
               wdata_d = req_in.wdata;
               cnt_d   = 2'h0;
               state_d = (eff_rgn == mmad_pkg::RGN_EXT) ? ST_SETUP : ST_INT;
            end
         end
         // Internal resources answer in one cycle
         ST_INT: begin
            case (rgn_q)
               mmad_pkg::RGN_ROM: rdata_d = rom_rdata_in;
               mmad_pkg::RGN_RAM: rdata_d = ram_rdata_in;
               default:           rdata_d = io_rd;
            endcase
            if (write_q && rgn_q == mmad_pkg::RGN_IO) begin
               if (addr_q[15:0] == mmad_pkg::XBANK_REG) index_x_bank_d = wdata_q[3:0];
               if (addr_q[15:0] == mmad_pkg::YBANK_REG) index_y_bank_d = wdata_q[3:0];
            end
            state_d = ST_DONE;
         end
         // Address settles on the pins before the strobe
         ST_SETUP: state_d = ST_STROBE;
         // Strobe for a least length, longer while wait is low
         ST_STROBE: begin
            if (cnt_q != mmad_pkg::STROBE_MIN) begin
               cnt_d = cnt_q + 2'h1;
            end else if (wait_n_q) begin
               rdata_d = p0_in;
               state_d = ST_DONE;
            end
         end
         // One-cycle completion
         ST_DONE:  state_d = ST_IDLE;
         default:  state_d = ST_IDLE;
      endcase
   end

   // Register the sequencer
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         state_q <= ST_IDLE;
         addr_q  <= 20'h00000;
         rgn_q   <= mmad_pkg::RGN_EXT;
         write_q <= 1'b0;
         wdata_q <= 8'h00;
         rdata_q <= 8'h00;
         cnt_q   <= 2'h0;
         index_x_bank_q <= mmad_pkg::BANK_RST;
         index_y_bank_q <= mmad_pkg::BANK_RST;
      end else begin
         state_q <= state_d;
         addr_q  <= addr_d;
         rgn_q   <= rgn_d;
         write_q <= write_d;
         wdata_q <= wdata_d;
         rdata_q <= rdata_d;
         cnt_q   <= cnt_d;
         index_x_bank_q <= index_x_bank_d;
         index_y_bank_q <= index_y_bank_d;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign req_ready_out = (state_q == ST_IDLE);
   assign done_out      = (state_q == ST_DONE);
   assign rdata_out     = rdata_q;
   assign boot_addr_out = mmad_pkg::BOOT_ADDR;

   // Internal port; ROM is never written
   always_comb begin
      int_out.addr    = addr_q[15:0];
      int_out.rom_sel = (state_q == ST_INT) && (rgn_q == mmad_pkg::RGN_ROM);
      int_out.ram_sel = (state_q == ST_INT) && (rgn_q == mmad_pkg::RGN_RAM);
      int_out.io_sel  = (state_q == ST_INT) && (rgn_q == mmad_pkg::RGN_IO);
      int_out.we      = (state_q == ST_INT) && write_q && (rgn_q != mmad_pkg::RGN_ROM);
      int_out.wdata   = wdata_q;
   end

   // Area flags for interrupt entry and DMA parameters
   assign vec_area_out  = (rgn_q == mmad_pkg::RGN_ROM) && (addr_q[15:0] >= mmad_pkg::VEC_LO)
                          && (addr_q[15:0] <= mmad_pkg::VEC_HI);
   assign dma_param_out = micro_dma_en_in && (rgn_q == mmad_pkg::RGN_RAM)
                          && (addr_q[15:0] >= mmad_pkg::DMA_LO)
                          && (addr_q[15:0] <= mmad_pkg::DMA_HI);

   // External pins: address held from latch, data driven only on write
   assign p1_out    = addr_q[7:0];
   assign p2_out    = addr_q[15:8];
   assign p0_out    = wdata_q;
   assign p0_oe_out = write_q && (rgn_q == mmad_pkg::RGN_EXT)
                      && (state_q == ST_SETUP || state_q == ST_STROBE);
   assign rd_n_out  = ~((state_q == ST_STROBE) && !write_q);
   assign wr_n_out  = ~((state_q == ST_STROBE) && write_q);

   // Port 4 bits chosen one by one between bank address and port latch
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_p4
         assign p4_out[gi] = p4_addr_sel_in[gi] ? addr_q[16 + gi] : p4_port_in[gi];
      end
   endgenerate

endmodule // mmad_decoder

// ===== mmad_monitor.sv
`timescale 1ns/100ps
// ------------------------------------------------
// Port checker for the address decoder
// ------------------------------------------------
module mmad_monitor (
   // Clock and reset
   input wire logic                clk_in,
   input wire logic                rst_in,
   // CPU side
   input wire logic                req_ready_out,
   input wire logic                done_out,
   input wire logic [15:0]         boot_addr_out,
   input wire mmad_pkg::mmad_int_t int_out,
   // External side
   input wire logic                wait_n_in,
   input wire logic                p0_oe_out,
   input wire logic                rd_n_out,
   input wire logic                wr_n_out,
   input wire logic                clk_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (rst_in);

   property p_clk_rst;
      $fell(rst_in) |-> clk_out ##1 clk_out ##1 !clk_out;
   endproperty
   a_clk_rst: assert property (p_clk_rst)
      else $error("clock out wrong after reset");
   property p_clk_div;
      $changed(clk_out) |=> $stable(clk_out) ##1 $changed(clk_out);
   endproperty
   a_clk_div: assert property (p_clk_div)
      else $error("clock out not quarter rate");
   property p_boot;
      boot_addr_out == 16'h0000;
   endproperty
   a_boot: assert property (p_boot)
      else $error("boot address wrong");
   // Internal access never touches the pins, answers next cycle
   property p_int_done;
      (int_out.rom_sel || int_out.ram_sel || int_out.io_sel)
         |-> (rd_n_out && wr_n_out) ##1 done_out;
   endproperty
   a_int_done: assert property (p_int_done)
      else $error("internal access timing wrong");
   property p_rd_oe;
      !rd_n_out |-> !p0_oe_out && wr_n_out;
   endproperty
   a_rd_oe: assert property (p_rd_oe)
      else $error("data bus driven during read");
   property p_wr_oe;
      !wr_n_out |-> p0_oe_out;
   endproperty
   a_wr_oe: assert property (p_wr_oe)
      else $error("data bus idle during write");
   property p_strobe4;
      $fell(rd_n_out && wr_n_out) |-> (!(rd_n_out && wr_n_out))[*4];
   endproperty
   a_strobe4: assert property (p_strobe4)
      else $error("strobe shorter than four cycles");
   property p_ext_done;
      $rose(rd_n_out && wr_n_out) |-> done_out ##1 req_ready_out;
   endproperty
   a_ext_done: assert property (p_ext_done)
      else $error("external cycle end not answered");
   // Five low samples cover the three-flop synchroniser delay
   property p_wait;
      (!wait_n_in)[*5] ##0 !rd_n_out |=> !rd_n_out;
   endproperty
   a_wait: assert property (p_wait)
      else $error("strobe ended during wait");
endmodule // mmad_monitor

// ===== mmad_ext_mem.sv
`timescale 1ns/100ps
// ------------------------------------------------
// External memory on the separate address and data bus
// ------------------------------------------------
module mmad_ext_mem (
   // Clock
   input  wire logic       clk_in,
   // Bus pins from the block
   input  wire logic [7:0] lo_in,
   input  wire logic [7:0] hi_in,
   input  wire logic [3:0] bank_in,
   input  wire logic [7:0] wdata_in,
   input  wire logic       drive_in,
   input  wire logic       rd_n_in,
   input  wire logic       wr_n_in,
   input  wire logic       stall_in,
   // Answer to the block
   output logic [7:0]      rdata_out,
   output logic            wait_n_out
);
   logic [7:0]  mem_q [logic [19:0]];  // Sparse 1M contents
   logic [19:0] addr;                  // Full bus address
   logic [7:0]  last_q = 8'h00;        // Last value driven
   assign addr = {bank_in, hi_in, lo_in};
   // Slow device holds wait from its own decode on; the block sees the pin
   // four cycles late, so wait raised only at the strobe would be missed
   assign wait_n_out = !stall_in;
   // Store on write strobe while the block drives
   always @(posedge clk_in) begin
      if (!wr_n_in && drive_in) begin
         mem_q[addr] = wdata_in;
      end
      if (!rd_n_in) begin
         last_q = rdata_out;
      end
   end
   // Released bus shows inverted junk, never a stale match
   always_comb begin
      if (!rd_n_in) begin
         rdata_out = mem_q.exists(addr) ? mem_q[addr] : addr[7:0] ^ 8'hC3;
      end else begin
         rdata_out = ~last_q;
      end
   end
endmodule // mmad_ext_mem

// ===== mmad_tb.sv
`timescale 1ns/100ps
module testbench;
   // ------------------------------------------------
   // Stimulus and observed pins
   // ------------------------------------------------
   logic clk_in = 1'b0, rst_in = 1'b1, req_valid_in = 1'b0;
   mmad_pkg::mmad_req_t req_in = '0;
   logic micro_dma_en_in = 1'b0, internal_rom_select_in = 1'b1, stall = 1'b0;
   logic [3:0] p4_addr_sel_in = 4'hF, p4_port_in = 4'h0, p4_out;
   logic req_ready_out, done_out, p0_oe_out, rd_n_out, wr_n_out, clk_out;
   logic vec_area_out, dma_param_out, wait_n_in;
   logic [7:0] rdata_out, p0_in, p0_out, p1_out, p2_out;
   logic [7:0] rom_rdata_in, ram_rdata_in, io_rdata_in;
   logic [15:0] boot_addr_out;
   mmad_pkg::mmad_int_t int_out;
   int errors = 0, n_compared = 0, cycles;
   always #5 clk_in = ~clk_in;
   // Internal memories answer with address patterns
   assign rom_rdata_in = int_out.addr[7:0] ^ 8'h5A;
   assign ram_rdata_in = int_out.addr[7:0] ^ 8'hA5;
   assign io_rdata_in  = int_out.addr[7:0];
   mmad_decoder u_dut (.clk_in, .rst_in, .req_valid_in, .req_in, .req_ready_out,
      .done_out, .rdata_out, .boot_addr_out, .int_out, .rom_rdata_in,
      .ram_rdata_in, .io_rdata_in, .vec_area_out, .dma_param_out,
      .micro_dma_en_in, .internal_rom_select_in, .wait_n_in, .p4_addr_sel_in,
      .p4_port_in, .p0_in, .p0_out, .p0_oe_out, .p1_out, .p2_out, .p4_out,
      .rd_n_out, .wr_n_out, .clk_out);
   mmad_ext_mem u_mem (.clk_in, .lo_in(p1_out), .hi_in(p2_out), .bank_in(p4_out),
      .wdata_in(p0_out), .drive_in(p0_oe_out), .rd_n_in(rd_n_out),
      .wr_n_in(wr_n_out), .stall_in(stall), .rdata_out(p0_in),
      .wait_n_out(wait_n_in));
   // ------------------------------------------------
   // Shared tasks
   // ------------------------------------------------
   task automatic finish_test;
      $display("errors %0d n_compared %0d", errors, n_compared);
      if (errors == 0 && n_compared > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [19:0] got, input logic [19:0] exp);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH t=%0t got %0h exp %0h", $time, got, exp);
      end
   endtask
   // One byte access; cycles counts edges from take to answer
   task automatic acc(input logic [19:0] a, input logic w, f, d, input logic [7:0] wd,
                      input mmad_pkg::mmad_bank_t b);
      @(posedge clk_in);
      req_valid_in <= 1'b1;
      req_in <= '{a, a[7:0], d, f, w, wd, b};
      do @(posedge clk_in); while (req_ready_out !== 1'b1);
      req_valid_in <= 1'b0;
      cycles = 0;
      while (done_out !== 1'b1 && cycles < 40) begin
         @(posedge clk_in);
         cycles++;
      end
      // An access that never answers ends the run as a failure
      if (done_out !== 1'b1) begin
         errors++;
         finish_test();
      end
   endtask
   // ------------------------------------------------
   // Scenarios
   // ------------------------------------------------
   task automatic t_rom;
      acc(20'h01FFF, 0, 1, 0, 0, mmad_pkg::BANK_NONE);
      chk(rdata_out, 8'hA5);
      chk(cycles, 2);
      acc(20'h00010, 0, 0, 0, 0, mmad_pkg::BANK_NONE);
      chk(vec_area_out, 1);
      acc(20'h00080, 0, 0, 0, 0, mmad_pkg::BANK_NONE);
      chk(vec_area_out, 0);
      acc(20'h02000, 0, 0, 0, 0, mmad_pkg::BANK_NONE);
      chk(rdata_out, 8'hC3);
      chk(cycles, 6);
   endtask
   task automatic t_ram;
      acc(20'h0FEC0, 0, 0, 0, 0, mmad_pkg::BANK_NONE);
      chk(rdata_out, 8'h65);
      acc(20'h0FFBF, 0, 0, 0, 0, mmad_pkg::BANK_NONE);
      chk(rdata_out, 8'h1A);
      acc(20'h0FFC0, 0, 0, 0, 0, mmad_pkg::BANK_NONE);
      chk(rdata_out, 8'hC0);
      acc(20'h0FFEF, 0, 0, 0, 0, mmad_pkg::BANK_NONE);
      chk(rdata_out, 8'hEF);
      micro_dma_en_in <= 1'b1;
      acc(20'h00010, 0, 0, 1, 0, mmad_pkg::BANK_NONE);
      chk(int_out.addr, 16'hFF10);
      chk(dma_param_out, 1);
      micro_dma_en_in <= 1'b0;
      acc(20'h00010, 0, 0, 1, 0, mmad_pkg::BANK_NONE);
      chk(dma_param_out, 0);
      chk(rdata_out, 8'hB5);
      acc(20'h000F0, 0, 0, 1, 0, mmad_pkg::BANK_NONE);
      chk(rdata_out, 8'h33);
   endtask
   task automatic t_bank;
      acc(20'h0FFEC, 0, 0, 0, 0, mmad_pkg::BANK_NONE);
      chk(rdata_out, 8'hF0);
      acc(20'h0FFEC, 1, 0, 0, 8'h03, mmad_pkg::BANK_NONE);
      acc(20'h0FFED, 1, 0, 0, 8'h05, mmad_pkg::BANK_NONE);
      acc(20'h0FFEC, 0, 0, 0, 0, mmad_pkg::BANK_NONE);
      chk(rdata_out, 8'hF3);
      acc(20'h01234, 1, 0, 0, 8'h5C, mmad_pkg::BANK_X);
      acc(20'h31234, 0, 0, 0, 0, mmad_pkg::BANK_NONE);
      chk(rdata_out, 8'h5C);
      acc(20'h35000, 1, 0, 0, 8'h11, mmad_pkg::BANK_NONE);
      acc(20'h05000, 1, 0, 0, 8'h77, mmad_pkg::BANK_NONE);
      acc(20'h35000, 0, 1, 0, 0, mmad_pkg::BANK_NONE);
      chk(rdata_out, 8'h77);
      acc(20'h35000, 0, 0, 0, 0, mmad_pkg::BANK_NONE);
      chk(rdata_out, 8'h11);
      // Mixed pin use: bits 0 and 2 bank, 1 and 3 port
      p4_addr_sel_in <= 4'h5;
      p4_port_in <= 4'hA;
      acc(20'h01234, 0, 0, 0, 0, mmad_pkg::BANK_Y);
      chk(p4_out, 4'hF);
      p4_addr_sel_in <= 4'hF;
   endtask
   // Stall the read for ten cycles; strobe must stretch
   task automatic t_wait;
      stall <= 1'b1;
      fork
         acc(20'h03000, 0, 0, 0, 0, mmad_pkg::BANK_NONE);
         begin
            repeat (10) @(posedge clk_in);
            stall <= 1'b0;
         end
      join
      chk(cycles > 8, 1);
      chk(rdata_out, 8'hC3);
   endtask
   // Strap low: low region goes to the external bus
   task automatic t_strap;
      internal_rom_select_in <= 1'b0;
      repeat (5) @(posedge clk_in);
      acc(20'h00100, 0, 1, 0, 0, mmad_pkg::BANK_NONE);
      chk(rdata_out, 8'hC3);
      chk(cycles, 6);
      internal_rom_select_in <= 1'b1;
      repeat (5) @(posedge clk_in);
   endtask
   // ------------------------------------------------
   // Main sequence and watchdog
   // ------------------------------------------------
   initial begin
      repeat (3) @(posedge clk_in);
      chk(clk_out, 1);
      chk(boot_addr_out, 16'h0000);
      rst_in <= 1'b0;
      t_rom();
      t_ram();
      t_bank();
      t_wait();
      t_strap();
      finish_test();
   end
   // Twenty-four accesses of under twenty cycles each; ample margin
   initial begin
      repeat (5000) @(posedge clk_in);
      errors++;
      finish_test();
   end
endmodule // testbench
bind mmad_decoder mmad_monitor u_mon (.clk_in, .rst_in, .req_ready_out, .done_out,
   .boot_addr_out, .int_out, .wait_n_in, .p0_oe_out, .rd_n_out, .wr_n_out, .clk_out);
